// [disk_break_request_control.sv]
// Break request, timing error and buffer register sequencing for the disk channel.
// How it works
// - Break enable from last bit, data field, normal.
// - No per-word write requests once sector count nearly ends.
// - Set pulse is OR of three sources.
// - Initial request for each sector's first out word.
// - Write-all request at parity window trailing edge.
// - Per-word request on enable, gate and clock.
// - Set-pulse trailing edge sets double flag if needed.
// - Grant clears double flag, else clears request.
// - Master clear resets request and double flags.
// - Timing error when request pending at new set.
// - Set pulse also sets buffer shift sync.
// - Into memory: address accept clears shift sync.
// - Out of memory: bus strobe clears shift sync.
// - Shift sync clearing sets shift enable, copies halves.
// - Half shift held two clocks (80 ns), then strobe, clear.
// - Into memory, no half shift: load shift register.
// - Out of memory, no half shift: load bus.
// - Bus strobe on I/O pulse with channel enable.
// - Shift register strobe needs shift, set, into.
// - Buffer cleared by master clear or trailing edges.
// - Direction out only for transfer with bit one.
// - Buffer-to-shift on last bit in data field.
// - Last bit window covers bit 35 writing.
`timescale 1ns/1ps

module disk_break_request_control (
  // Clock and reset
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst,
  // Wishbone slave
  input  wire logic                       i_wb_cyc,
  input  wire logic                       i_wb_stb,
  input  wire logic                       i_wb_we,
  input  wire logic [7:0]                 i_wb_adr,
  input  wire logic [3:0]                 i_wb_sel,
  input  wire logic [31:0]                i_wb_dat,
  output logic      [31:0]                o_wb_dat,
  output logic                            o_wb_ack,
  // Controller levels, same clock
  input  wire break_request_pkg::seq_in_t i_seq,
  input  wire logic                       i_master_clear,
  input  wire logic                       i_function_delay,
  input  wire logic                       i_io_sync,
  // Host channel levels, asynchronous
  input  wire break_request_pkg::chan_in_t i_chan,
  // Data sources for the buffer
  input  wire logic [35:0]                i_shift_register,
  input  wire logic [17:0]                i_io_bus,
  // Outputs to channel and datapath
  output logic                            o_break_request,
  output logic                            o_double_break_flag,
  output logic                            o_timing_error_flag,
  output logic                            o_direction_into_memory,
  output logic                            o_buffer_to_shift,
  output logic                            o_half_shift_enable,
  output logic [35:0]                     o_buffer_register
);

  // Two-flop synchroniser for the channel levels
  break_request_pkg::chan_in_t chan_meta_q;   // First stage, read only by second
  break_request_pkg::chan_in_t chan_q;        // Safe synchronised copy
  break_request_pkg::chan_in_t chan_prev_q;   // Previous copy for edge detect

  // Software control bits
  logic [break_request_pkg::CTL_WIDTH-1:0] control_q;
  logic status_clear_q;                       // One-cycle status clear strobe

  // Request sequencing state
  logic init_term_q;                          // Previous initial-request level
  logic prehdr_term_q;                        // Previous pre-header level
  logic word_term_q;                          // Previous per-word level
  logic set_request_q;                        // Delayed set pulse for trailing edge
  logic init_pulse_q;                         // Delayed initial pulse for trailing edge
  logic clear_en_q;                           // Previous buffer-clear enable
  logic break_request_q;
  logic double_break_q;
  logic timing_error_q;
  logic shift_sync_q;
  logic shift_enable_q;
  logic [1:0] half_cnt_q;                     // Delay line emulation
  logic [35:0] buffer_q;
  logic buffer_to_shift_q;
  logic into_q;
  logic half_q;
  logic ack_q;
  logic [31:0] rd_q;

  // Decoded control fields
  logic fn_one;
  logic fn_two;
  logic transfer_fn;
  logic normal_mode;
  logic all_mode;
  logic write_data_enable;
  assign fn_one            = control_q[break_request_pkg::CTL_FN_ONE_BIT];
  assign fn_two            = control_q[break_request_pkg::CTL_FN_TWO_BIT];
  assign transfer_fn       = control_q[break_request_pkg::CTL_TRANSFER_BIT];
  assign normal_mode       = control_q[break_request_pkg::CTL_NORMAL_BIT];
  assign all_mode          = control_q[break_request_pkg::CTL_ALL_MODE_BIT];
  assign write_data_enable = control_q[break_request_pkg::CTL_WDE_BIT];

  // Combinational terms
  logic into_memory;
  logic break_request_enable;
  logic init_term;
  logic prehdr_term;
  logic word_term;
  logic initial_request;
  logic prehdr_request;
  logic word_request;
  logic set_request;
  logic set_trailing;
  logic grant_lead;
  logic grant_trail;
  logic address_accept;
  logic io_strobe;
  logic sync_clear;
  logic shift_enable_set;
  logic delayed_edge;
  logic half_shift_enable;
  logic load_from_shift_register;
  logic load_from_io_bus;
  logic sr_strobe;
  logic buffer_clear;

  // Out of memory only for transfer functions with bit one set
  assign into_memory = ~(fn_one & transfer_fn);

  // Enable term; near-end stops further per-word write requests this sector
  assign break_request_enable = (i_seq.last_bit_write_window
                                 & ~i_seq.sector_count_near_end
                                 & ~i_seq.sector_count_overflow
                                 & normal_mode
                                 & i_seq.data_field)
                                | (i_seq.shift_to_buffer & into_memory);

  // First out word of each sector
  assign init_term = ~into_memory & normal_mode & ~i_seq.word_count_overflow
                     & ((i_seq.compare_flag & fn_two)
                        | (i_seq.final_sync_word & ~fn_two & write_data_enable));

  // Level true after the parity window falls in the pre-header word
  assign prehdr_term = ~i_seq.parity_write_window & i_seq.pre_header & all_mode;

  // One request per word, read words and later write words
  assign word_term = break_request_enable & chan_q.data_gate
                     & chan_q.recovered_bit_clock & ~i_seq.word_count_overflow
                     & (into_memory | ~i_seq.sector_count_near_end);

  // Leading-edge strobes of each source
  assign initial_request = init_term & ~init_term_q;
  assign prehdr_request  = prehdr_term & ~prehdr_term_q;
  assign word_request    = word_term & ~word_term_q;
  assign set_request     = initial_request | prehdr_request | word_request;
  assign set_trailing    = set_request_q & ~set_request;

  // Channel edges
  assign grant_lead     = chan_q.channel_grant & ~chan_prev_q.channel_grant;
  assign grant_trail    = ~chan_q.channel_grant & chan_prev_q.channel_grant;
  assign address_accept = grant_trail & chan_q.channel_enable_flag;
  assign io_strobe      = chan_q.io_pulse_four & ~chan_prev_q.io_pulse_four
                          & chan_q.channel_enable_flag;

  // Shift sync clears by direction
  assign sync_clear = (address_accept & into_memory)
                      | (io_strobe & ~into_memory);
  assign shift_enable_set = shift_sync_q & sync_clear & ~set_request;

  // Delay line end and hold of the half-shift enable
  assign delayed_edge      = shift_enable_q
                             & (half_cnt_q == 2'(break_request_pkg::HALF_SHIFT_CYCLES));
  assign half_shift_enable = shift_enable_q;

  // Load source selection
  assign load_from_shift_register = into_memory & ~half_shift_enable;
  assign load_from_io_bus         = ~into_memory & ~half_shift_enable;
  assign sr_strobe = i_seq.shift_to_buffer & set_request & into_memory;
  assign buffer_clear = i_master_clear | init_pulse_q
                        | (clear_en_q & ~i_seq.buffer_clear_enable);

  // Synchroniser and edge history
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      chan_meta_q <= '0;
      chan_q      <= '0;
      chan_prev_q <= '0;
    end else begin
      chan_meta_q <= i_chan;
      chan_q      <= chan_meta_q;
      chan_prev_q <= chan_q;
    end
  end

  // Registered copies of the source levels for edge detection
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      init_term_q   <= 1'b0;
      prehdr_term_q <= 1'b0;
      word_term_q   <= 1'b0;
      set_request_q <= 1'b0;
      init_pulse_q  <= 1'b0;
      clear_en_q    <= 1'b0;
    end else begin
      init_term_q   <= init_term;
      prehdr_term_q <= prehdr_term;
      word_term_q   <= word_term;
      set_request_q <= set_request;
      init_pulse_q  <= initial_request;
      clear_en_q    <= i_seq.buffer_clear_enable;
    end
  end

  // Break request: set wins over a grant in the same cycle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      break_request_q <= 1'b0;
    end else if (i_master_clear) begin
      break_request_q <= 1'b0;
    end else if (set_request) begin
      break_request_q <= 1'b1;
    end else if (grant_lead && !double_break_q) begin
      break_request_q <= 1'b0;
    end
  end

  // Double-break flag, strobed at the set pulse trailing edge
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      double_break_q <= 1'b0;
    end else if (i_master_clear) begin
      double_break_q <= 1'b0;
    end else if (set_trailing) begin
      double_break_q <= ~i_seq.word_count_near_end;
    end else if (grant_lead) begin
      double_break_q <= 1'b0;
    end
  end

  // Timing error: new set while request still up; set wins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      timing_error_q <= 1'b0;
    end else if (set_request && break_request_q) begin
      timing_error_q <= 1'b1;
    end else if (i_master_clear || status_clear_q || i_function_delay) begin
      timing_error_q <= 1'b0;
    end
  end

  // Shift sync: set pulse wins over its clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      shift_sync_q <= 1'b0;
    end else if (set_request) begin
      shift_sync_q <= 1'b1;
    end else if (i_master_clear) begin
      shift_sync_q <= 1'b0;
    end else if (sync_clear) begin
      shift_sync_q <= 1'b0;
    end
  end

  // Shift enable and the delay line that ends it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      shift_enable_q <= 1'b0;
      half_cnt_q     <= 2'h0;
    end else if (i_master_clear || i_io_sync || delayed_edge) begin
      shift_enable_q <= 1'b0;
      half_cnt_q     <= 2'h0;
    end else if (shift_enable_set) begin
      shift_enable_q <= 1'b1;
      half_cnt_q     <= 2'h1;
    end else if (shift_enable_q) begin
      half_cnt_q     <= half_cnt_q + 2'h1;
    end
  end

  // Buffer register: clear, half shift, bus load, shift register load
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      buffer_q <= break_request_pkg::BUFFER_RESET;
    end else if (buffer_clear) begin
      buffer_q <= break_request_pkg::BUFFER_RESET;
    end else if (delayed_edge) begin
      buffer_q[17:0] <= buffer_q[35:18];
    end else if (io_strobe && load_from_io_bus) begin
      buffer_q[35:18] <= i_io_bus;
    end else if (sr_strobe && load_from_shift_register) begin
      buffer_q <= i_shift_register;
    end
  end

  // Registered datapath outputs; window length is set by the bit timing
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      buffer_to_shift_q <= 1'b0;
      into_q            <= 1'b1;
      half_q            <= 1'b0;
    end else begin
      buffer_to_shift_q <= i_seq.last_bit_write_window & normal_mode
                           & i_seq.data_field & ~i_seq.sector_count_overflow;
      into_q            <= into_memory;
      half_q            <= half_shift_enable;
    end
  end

  // Wishbone: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= i_wb_cyc & i_wb_stb & ~ack_q;
    end
  end

  // Control register write and status clear strobe, taken at the ack edge
  // so a write lands exactly where the master samples ack high
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      control_q      <= break_request_pkg::CONTROL_RESET;
      status_clear_q <= 1'b0;
    end else begin
      status_clear_q <= 1'b0;
      if (i_wb_cyc && i_wb_stb && i_wb_we && ack_q && i_wb_sel[0]) begin
        if (i_wb_adr == break_request_pkg::CONTROL_OFS) begin
          control_q <= i_wb_dat[break_request_pkg::CTL_WIDTH-1:0];
        end else if (i_wb_adr == break_request_pkg::STATUS_OFS) begin
          // Writing a one to the timing bit clears it
          status_clear_q <= i_wb_dat[break_request_pkg::STS_TIMING_BIT];
        end
      end
    end
  end

  // Read data, registered alongside ack; unmapped reads give zero
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rd_q <= 32'h00000000;
    end else begin
      rd_q <= 32'h00000000;
      if (i_wb_cyc && i_wb_stb && !i_wb_we && !ack_q) begin
        case (i_wb_adr)
          break_request_pkg::CONTROL_OFS: begin
            rd_q[break_request_pkg::CTL_WIDTH-1:0] <= control_q;
          end
          break_request_pkg::STATUS_OFS: begin
            rd_q[break_request_pkg::STS_BREAK_BIT]    <= break_request_q;
            rd_q[break_request_pkg::STS_DOUBLE_BIT]   <= double_break_q;
            rd_q[break_request_pkg::STS_TIMING_BIT]   <= timing_error_q;
            rd_q[break_request_pkg::STS_SYNC_BIT]     <= shift_sync_q;
            rd_q[break_request_pkg::STS_SHIFT_EN_BIT] <= shift_enable_q;
            rd_q[break_request_pkg::STS_INTO_BIT]     <= into_memory;
            rd_q[break_request_pkg::STS_HALF_BIT]     <= half_shift_enable;
          end
          break_request_pkg::BUFFER_LO_OFS: begin
            rd_q[17:0] <= buffer_q[17:0];
          end
          break_request_pkg::BUFFER_HI_OFS: begin
            rd_q[17:0] <= buffer_q[35:18];
          end
          default: begin
            rd_q <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // Outputs straight from flip-flops
  assign o_wb_ack                = ack_q;
  assign o_wb_dat                = rd_q;
  assign o_break_request         = break_request_q;
  assign o_double_break_flag     = double_break_q;
  assign o_timing_error_flag     = timing_error_q;
  assign o_direction_into_memory = into_q;
  assign o_buffer_to_shift       = buffer_to_shift_q;
  assign o_half_shift_enable     = half_q;
  assign o_buffer_register       = buffer_q;

endmodule

// [break_request_pkg.sv]
// Package for the disk break-request controller: offsets, fields, timing, carriers.
package break_request_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] CONTROL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] BUFFER_LO_OFS = 8'h08;
  localparam logic [7:0] BUFFER_HI_OFS = 8'h0C;

  // Control register field positions
  localparam int CTL_FN_ONE_BIT    = 0;
  localparam int CTL_FN_TWO_BIT    = 1;
  localparam int CTL_TRANSFER_BIT  = 2;
  localparam int CTL_NORMAL_BIT    = 3;
  localparam int CTL_ALL_MODE_BIT  = 4;
  localparam int CTL_WDE_BIT       = 5;
  localparam int CTL_WIDTH         = 6;

  // Status register field positions
  localparam int STS_BREAK_BIT     = 0;
  localparam int STS_DOUBLE_BIT    = 1;
  localparam int STS_TIMING_BIT    = 2;
  localparam int STS_SYNC_BIT      = 3;
  localparam int STS_SHIFT_EN_BIT  = 4;
  localparam int STS_INTO_BIT      = 5;
  localparam int STS_HALF_BIT      = 6;

  // Reset values
  localparam logic [CTL_WIDTH-1:0] CONTROL_RESET = 6'h00;
  localparam logic [35:0]          BUFFER_RESET  = 36'h000000000;

  // Timing: clock rate and half-shift hold time
  localparam int CLK_PERIOD_PS      = 40000;
  localparam int HALF_SHIFT_PS      = 50000;
  localparam int HALF_SHIFT_CYCLES  = (HALF_SHIFT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Levels from the format sequencer and counters, same clock domain
  typedef struct packed {
    logic last_bit_write_window;
    logic parity_write_window;
    logic data_field;
    logic pre_header;
    logic final_sync_word;
    logic compare_flag;
    logic shift_to_buffer;
    logic buffer_clear_enable;
    logic sector_count_near_end;
    logic sector_count_overflow;
    logic word_count_near_end;
    logic word_count_overflow;
  } seq_in_t;

  // Levels from the host channel logic, asynchronous to our clock
  typedef struct packed {
    logic channel_grant;
    logic channel_enable_flag;
    logic io_pulse_four;
    logic recovered_bit_clock;
    logic data_gate;
  } chan_in_t;

endpackage

// [brc_checker.sv]
// Port-level checker for the disk break-request controller.
`timescale 1ns/1ps
module brc_checker (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Bus and clear inputs
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        o_wb_ack,
  input  wire logic [31:0] o_wb_dat,
  input  wire logic        i_master_clear,
  // Watched outputs
  input  wire logic        o_break_request,
  input  wire logic        o_double_break_flag,
  input  wire logic        o_timing_error_flag,
  input  wire logic        o_half_shift_enable,
  input  wire logic [35:0] o_buffer_register
);
  // One clock domain, reset disables every check
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  chk_ack_single_pulse: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus ack not a single pulse after request");
  chk_read_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data not zero outside ack");
  chk_clear_flags: assert property (i_master_clear |=> !o_break_request && !o_double_break_flag)
    else $error("master clear left request flags set");
  chk_clear_buffer: assert property (i_master_clear |=> o_buffer_register == 36'h0)
    else $error("master clear left buffer set");
  chk_error_cause: assert property ($rose(o_timing_error_flag) |-> $past(o_break_request))
    else $error("timing error without pending request");
  chk_double_with_rq: assert property ($rose(o_double_break_flag) |-> o_break_request)
    else $error("double flag set without request");
  chk_double_keeps_rq: assert property ($fell(o_double_break_flag) && !$past(i_master_clear)
    |-> o_break_request)
    else $error("first grant dropped request of a pair");
  chk_half_shift_len: assert property ($rose(o_half_shift_enable)
    |-> o_half_shift_enable [*2] ##1 !o_half_shift_enable)
    else $error("half shift enable wrong length");
  chk_halves_copied: assert property ($fell(o_half_shift_enable)
    |-> o_buffer_register[17:0] == o_buffer_register[35:18])
    else $error("upper half not copied to lower half");
endmodule

bind disk_break_request_control brc_checker chk_u (.i_clk_sys, .i_rst, .i_wb_cyc, .i_wb_stb,
  .o_wb_ack, .o_wb_dat, .i_master_clear, .o_break_request, .o_double_break_flag,
  .o_timing_error_flag, .o_half_shift_enable, .o_buffer_register);

// [chan_partner.sv]
// Behavioural host channel: grants breaks and sends bus words.
`timescale 1ns/1ps
module chan_partner (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Bench enable and device view
  input  wire logic        i_go,
  input  wire logic        i_break_request,
  input  wire logic        i_into,
  // Channel lines
  output logic             o_grant,
  output logic             o_enable,
  output logic             o_io_pulse,
  output logic [17:0]      o_io_bus
);
  logic [17:0] word_q; // Next bus word, steps once per grant
  // Undriven bus shows the inverse so stale data never matches
  assign o_io_bus = o_io_pulse ? word_q : ~word_q;
  // One grant for each look at a raised request
  always begin
    o_grant    <= 1'b0;
    o_enable   <= 1'b0;
    o_io_pulse <= 1'b0;
    @(posedge i_clk_sys);
    if (i_rst) begin
      word_q <= 18'h12300;
    end else if (i_go && i_break_request) begin
      repeat (3) @(posedge i_clk_sys);
      o_grant    <= 1'b1;
      o_enable   <= 1'b1;
      o_io_pulse <= !i_into;
      repeat (3) @(posedge i_clk_sys);
      o_grant    <= 1'b0;
      o_io_pulse <= 1'b0;
      @(posedge i_clk_sys);
      word_q <= word_q + 18'h1;
      // Enable outlasts the grant so address accept can qualify
      repeat (4) @(posedge i_clk_sys);
    end
  end
endmodule

// [tb_top.sv]
// Self-checking bench for the disk break-request controller.
`timescale 1ns/1ps
module tb_top;
  localparam logic [35:0] SR_WORD = 36'h9ABCD1234; // Fixed shift register word
  logic        i_clk_sys, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
  logic [7:0]  i_wb_adr;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  logic        i_master_clear, i_function_delay, go, vfo, gate, grant, ena, iop;
  logic        o_break_request, o_double_break_flag, o_timing_error_flag;
  logic        o_direction_into_memory, o_half_shift_enable, b2s;
  logic [35:0] o_buffer_register;
  logic [17:0] i_io_bus;
  int          err_total, check_count;
  int          cyc_n = 0; // Timeout counter
  break_request_pkg::seq_in_t  i_seq;
  break_request_pkg::chan_in_t i_chan;
  assign i_chan = {grant, ena, iop, vfo, gate};

  disk_break_request_control dut_u (.i_clk_sys, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .i_wb_adr, .i_wb_sel(4'hF), .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_seq, .i_master_clear,
    .i_function_delay, .i_io_sync(1'b0), .i_chan, .i_shift_register(SR_WORD), .i_io_bus,
    .o_break_request, .o_double_break_flag, .o_timing_error_flag, .o_direction_into_memory,
    .o_buffer_to_shift(b2s), .o_half_shift_enable, .o_buffer_register);
  chan_partner partner_u (.i_clk_sys, .i_rst, .i_go(go), .i_break_request(o_break_request),
    .i_into(o_direction_into_memory), .o_grant(grant), .o_enable(ena), .o_io_pulse(iop),
    .o_io_bus(i_io_bus));

  // 25 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge i_clk_sys) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_total++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("Checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Classic single cycle; waits for ack, never assumes latency
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do @(posedge i_clk_sys); while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic wait_rq(input logic v);
    repeat (200) if (o_break_request !== v) @(posedge i_clk_sys);
    chk("break_request", v, o_break_request);
  endtask
  // One-cycle master clear, then let the cleared state settle
  task automatic mclr();
    i_master_clear <= 1'b1;
    tick(1);
    i_master_clear <= 1'b0;
    tick(2);
  endtask
  task automatic rise_cmp();
    i_seq.compare_flag <= 1'b1;
    tick(3);
    i_seq.compare_flag <= 1'b0;
    tick(3);
  endtask

  // Reset state, status and an unmapped place
  task automatic t_reset();
    chk("direction", 1, o_direction_into_memory);
    chk("flags", 0, {o_break_request, o_double_break_flag, o_timing_error_flag});
    chk("buffer", 0, o_buffer_register);
    wb(0, break_request_pkg::STATUS_OFS, 0);
    chk("status", 32'h20, rd);
    wb(0, 8'h10, 0);
    chk("unmapped", 0, rd);
  endtask
  // Every combination of function bit one and the transfer bit
  task automatic t_dir();
    logic [5:0] ctl [4] = '{6'h00, 6'h01, 6'h04, 6'h05};
    for (int k = 0; k < 4; k++) begin
      wb(1, break_request_pkg::CONTROL_OFS, {26'h0, ctl[k]});
      wb(0, break_request_pkg::CONTROL_OFS, 0);
      chk("control", {26'h0, ctl[k]}, rd);
      chk("direction", k != 3, o_direction_into_memory);
    end
  endtask
  // Out transfer: initial request, one or two grants, bus words
  task automatic t_out(input logic near, input logic [35:0] buf_exp);
    go <= 1'b1;
    i_seq.word_count_near_end <= near;
    wb(1, break_request_pkg::CONTROL_OFS, 32'h0F);
    i_seq.compare_flag <= 1'b1;
    wait_rq(1);
    tick(2);
    chk("double", !near, o_double_break_flag);
    i_seq.compare_flag <= 1'b0;
    wait_rq(0);
    tick(8);
    chk("double", 0, o_double_break_flag);
    chk("buffer_out", buf_exp, o_buffer_register);
  endtask
  // New set while pending, both clears, then master clear
  task automatic t_err();
    go <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      rise_cmp();
      rise_cmp();
      chk("timing_error", 1, o_timing_error_flag);
      if (k == 0) begin
        wb(0, break_request_pkg::STATUS_OFS, 0);
        chk("status_error", 1, rd[2]);
        wb(1, break_request_pkg::STATUS_OFS, 32'h4);
      end else begin
        i_function_delay <= 1'b1;
        tick(1);
        i_function_delay <= 1'b0;
      end
      tick(2);
      chk("timing_error", 0, o_timing_error_flag);
    end
    mclr();
    chk("clear_flags", 0, {o_break_request, o_double_break_flag});
    chk("clear_buffer", 0, o_buffer_register);
  endtask
  // Into memory: per-word request, shift register load, accept shift
  task automatic t_into();
    wb(1, break_request_pkg::CONTROL_OFS, 32'h08);
    go <= 1'b1;
    i_seq.shift_to_buffer <= 1'b1;
    i_seq.data_field <= 1'b1;
    gate <= 1'b1;
    tick(2);
    vfo <= 1'b1;
    wait_rq(1);
    chk("buffer_load", SR_WORD, o_buffer_register);
    vfo <= 1'b0;
    wait_rq(0);
    tick(8);
    chk("buffer_in", {SR_WORD[35:18], SR_WORD[35:18]}, o_buffer_register);
    // Last-bit window in the data field moves the buffer on, not after overflow
    i_seq.last_bit_write_window <= 1'b1;
    tick(2);
    chk("buffer_to_shift", 1, b2s);
    i_seq.sector_count_overflow <= 1'b1;
    tick(2);
    chk("buffer_to_shift", 0, b2s);
    i_seq.last_bit_write_window <= 1'b0;
    // Buffer holds a word here, so the clear is really seen
    mclr();
    chk("clear_buffer", 0, o_buffer_register);
  endtask

  // Main sequence
  initial begin
    i_rst = 1'b1;
    {i_wb_cyc, i_wb_stb, i_wb_we, i_master_clear, i_function_delay, go, vfo, gate} = 8'h00;
    i_wb_adr = 8'h00;
    i_wb_dat = 32'h0;
    i_seq = '0;
    err_total = 0;
    check_count = 0;
    tick(8);
    i_rst <= 1'b0;
    tick(1);
    t_reset();
    t_dir();
    t_out(1'b0, {18'h12301, 18'h12300});
    t_out(1'b1, {18'h12302, 18'h12302});
    t_err();
    t_into();
    results();
  end
endmodule
